/* File: phy_strap_override_status_regs.sv */
// Chosen here: the AHB-Lite register port.
module phy_strap_override_status_regs
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wake_enable_strap_pin,
  input  wire logic [1:0]  phy_addr_strap,
  input  wire logic        rmii_strap_pin,
  input  wire logic        rx_symbol_error,
  input  wire logic [1:0]  mmd_wake_pin_select,
  output logic             reduced_amplitude_ten_meg,
  output logic             power_wake_event_enable,
  output logic      [1:0]  wake_pin_function,
  output logic             broadcast_disable,
  output logic             rmii_back_to_back,
  output logic             nand_tree_mode,
  output logic             rmii_mode,
  output logic      [4:0]  phy_address,
  output logic             irq
);

  typedef struct packed {
    logic [15:0]                  afe4;
    logic [15:0]                  errcnt;
    logic [15:0]                  ovr;
    logic [psos_pkg::INT_W-1:0]   int_sts;
    logic [psos_pkg::INT_W-1:0]   int_msk;
    logic                         wr_pend;
    logic [5:0]                   wr_idx;
    logic [31:0]                  rdata;
  } psos_regs_t;

  psos_regs_t   q;
  psos_regs_t   d;
  psos_strap_if strap_bus ();

  logic         acc;
  logic         rd_acc;
  logic [5:0]   rd_idx;
  logic         rd_cnt;

  psos_strap_sampler u_sampler
  (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .wake_enable_strap_pin (wake_enable_strap_pin),
    .phy_addr_strap        (phy_addr_strap),
    .rmii_strap_pin        (rmii_strap_pin),
    .strap                 (strap_bus.producer)
  );

  // Unused upper address bits must be zero, so no register aliases.
  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    if ((addr[31:8] != 24'h000000) || (addr[1:0] != 2'h0))
    begin
      idx = psos_pkg::IDX_NONE;
    end
    return idx;
  endfunction

  function automatic logic [31:0] read_word(input logic [5:0] idx,
                                            input psos_regs_t r,
                                            input logic [1:0] paddr,
                                            input logic prmii);
    logic [31:0] w;
    w = 32'h00000000;
    case (idx)
      psos_pkg::IDX_AFE4:    w[15:0] = r.afe4;
      psos_pkg::IDX_ERRCNT:  w[15:0] = r.errcnt;
      psos_pkg::IDX_OVR:     w[15:0] = r.ovr;
      psos_pkg::IDX_STS:
      begin
        w[psos_pkg::STS_ADDR_LSB+:2] = paddr;
        w[psos_pkg::STS_RMII_BIT]    = prmii;
      end
      psos_pkg::IDX_INT_STS: w[psos_pkg::INT_W-1:0] = r.int_sts;
      psos_pkg::IDX_INT_MSK: w[psos_pkg::INT_W-1:0] = r.int_msk;
      default:               w = 32'h00000000;
    endcase
    return w;
  endfunction

  assign acc    = hsel && htrans[1] && hready;
  assign rd_acc = acc && !hwrite;
  assign rd_idx = reg_index(haddr);
  assign rd_cnt = rd_acc && (rd_idx == psos_pkg::IDX_ERRCNT);

  // Read data is taken from the next state so that a read right behind a
  // write, or beside a counted frame, sees the newest value.
  always_comb
  begin
    d = q;
    d.wr_pend = acc && hwrite;
    d.wr_idx  = rd_idx;
    if (q.wr_pend)
    begin
      case (q.wr_idx)
        psos_pkg::IDX_AFE4:    d.afe4 = hwdata[15:0];
        psos_pkg::IDX_OVR:
        begin
          d.ovr = hwdata[15:0] & psos_pkg::OVR_WMASK;
        end
        psos_pkg::IDX_INT_STS:
        begin
          d.int_sts = q.int_sts & ~hwdata[psos_pkg::INT_W-1:0];
        end
        psos_pkg::IDX_INT_MSK:
        begin
          d.int_msk = hwdata[psos_pkg::INT_W-1:0];
        end
        default:
        begin
          d.afe4 = q.afe4;
        end
      endcase
    end
    if (strap_bus.captured)
    begin
      d.ovr[psos_pkg::OVR_WAKE_BIT] = strap_bus.wake_en;
    end
    // Status bits are set after the write-one clear, so an event wins.
    if (rx_symbol_error)
    begin
      d.errcnt = q.errcnt + 16'h0001;
      d.int_sts[psos_pkg::INT_ERR] = 1'b1;
      if (q.errcnt == psos_pkg::ERRCNT_MAX)
      begin
        d.int_sts[psos_pkg::INT_OVF] = 1'b1;
      end
    end
    if (rd_acc)
    begin
      d.rdata = read_word(rd_idx, d, strap_bus.phy_addr, strap_bus.rmii);
      if (rd_cnt)
      begin
        d.errcnt = psos_pkg::ERRCNT_RST;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q         <= '0;
      q.afe4    <= psos_pkg::AFE4_RST;
      q.errcnt  <= psos_pkg::ERRCNT_RST;
      q.ovr     <= psos_pkg::OVR_RST;
      q.int_sts <= psos_pkg::INT_RST;
      q.int_msk <= psos_pkg::INT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign hrdata                    = q.rdata;
  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign reduced_amplitude_ten_meg = q.afe4[psos_pkg::AFE4_AMP_BIT];
  assign power_wake_event_enable   = q.ovr[psos_pkg::OVR_WAKE_BIT];
  // The event pins keep their default function while wake is disabled.
  assign wake_pin_function         = q.ovr[psos_pkg::OVR_WAKE_BIT]
                                     ? mmd_wake_pin_select
                                     : psos_pkg::WAKE_PIN_OFF;
  assign broadcast_disable         = q.ovr[psos_pkg::OVR_BCAST];
  assign rmii_back_to_back         = q.ovr[psos_pkg::OVR_B2B];
  assign nand_tree_mode            = q.ovr[psos_pkg::OVR_NAND];
  assign rmii_mode                 = q.ovr[psos_pkg::OVR_RMII];
  assign phy_address               = {3'h0, strap_bus.phy_addr};
  assign irq                       = |(q.int_sts & q.int_msk);

  a_amp_set: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_AFE4)
    && hwdata[psos_pkg::AFE4_AMP_BIT] |=> reduced_amplitude_ten_meg)
    else $error("Reduced amplitude not selected after write of one.");

  a_amp_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_AFE4)
    && !hwdata[psos_pkg::AFE4_AMP_BIT] |=> !reduced_amplitude_ten_meg)
    else $error("Standard amplitude not restored after write of zero.");

  a_cnt_counts: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_symbol_error && !rd_cnt |=> q.errcnt == $past(q.errcnt) + 16'h0001)
    else $error("Symbol error frame was not counted.");

  a_cnt_read_clear: assert property
    (@(posedge hclk) disable iff (!hresetn)
    rd_cnt ##1 !rx_symbol_error |=> q.errcnt == 16'h0000)
    else $error("Counter did not clear after it was read.");

  a_cnt_read_value: assert property
    (@(posedge hclk) disable iff (!hresetn)
    rd_cnt && !rx_symbol_error |=> hrdata[15:0] == $past(q.errcnt))
    else $error("Counter read returned the wrong count.");

  a_wake_strap: assert property (@(posedge hclk) disable iff (!hresetn)
    strap_bus.captured |=> power_wake_event_enable == $past(strap_bus.wake_en))
    else $error("Wake enable did not take the strap value.");

  a_wake_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !power_wake_event_enable |-> wake_pin_function == psos_pkg::WAKE_PIN_OFF)
    else $error("Event pins changed function while wake disabled.");

  a_ovr_reserved: assert property
    (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_OVR) |=>
    !q.ovr[psos_pkg::OVR_RSVD_RO]
    && (q.ovr[14:11] == $past(hwdata[14:11]))
    && (q.ovr[8:7] == $past(hwdata[8:7]))
    && (q.ovr[4:2] == $past(hwdata[4:2])) && (q.ovr[0] == $past(hwdata[0])))
    else $error("Override reserved bits misbehave on write.");

  a_mode_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_OVR) |=>
    (rmii_back_to_back == $past(hwdata[psos_pkg::OVR_B2B]))
    && (nand_tree_mode == $past(hwdata[psos_pkg::OVR_NAND]))
    && (broadcast_disable == $past(hwdata[psos_pkg::OVR_BCAST]))
    && (rmii_mode == $past(hwdata[psos_pkg::OVR_RMII])))
    else $error("Override mode outputs do not follow the write.");

  a_addr_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    (phy_address == 5'h00) || (phy_address == 5'h03))
    else $error("Strapped address outside the supported pair.");

  a_status_stable: assert property
    (@(posedge hclk) disable iff (!hresetn)
    !strap_bus.captured |-> $stable(phy_address))
    else $error("Address status changed without a strap capture.");

  a_irq_event: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_symbol_error && q.int_msk[psos_pkg::INT_ERR] |=> irq)
    else $error("Unmasked symbol error did not raise the interrupt.");

  a_sts_w1c: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_INT_STS)
    && hwdata[psos_pkg::INT_ERR] && !rx_symbol_error
    |=> !q.int_sts[psos_pkg::INT_ERR])
    else $error("Write of one did not clear the event status.");

  a_event_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_symbol_error |=> q.int_sts[psos_pkg::INT_ERR])
    else $error("Symbol error event did not set its status bit.");

  a_cnt_readonly: assert property
    (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_ERRCNT)
    && !rx_symbol_error && !rd_cnt |=> $stable(q.errcnt))
    else $error("Write changed the read-only symbol error count.");

  a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.ovr[psos_pkg::OVR_RSVD_RO])
    else $error("Read-only reserved override bit was set.");

  a_status_read: assert property
    (@(posedge hclk) disable iff (!hresetn)
    rd_acc && (rd_idx == psos_pkg::IDX_STS) |=>
    (hrdata[14:13] == $past(strap_bus.phy_addr))
    && (hrdata[1] == $past(strap_bus.rmii)))
    else $error("Strap status read returned the wrong value.");

  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_acc && (rd_idx < psos_pkg::IDX_AFE4) |=> (hrdata == 32'h00000000))
    else $error("Unmapped register read returned nonzero data.");

  a_wake_select: assert property (@(posedge hclk) disable iff (!hresetn)
    power_wake_event_enable |-> wake_pin_function == mmd_wake_pin_select)
    else $error("Event pins ignore the selection while wake enabled.");

  a_afe_write: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && (q.wr_idx == psos_pkg::IDX_AFE4)
    |=> q.afe4 == $past(hwdata[15:0]))
    else $error("Control register did not take the written word.");

  a_rdata_stands: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_acc |=> $stable(hrdata))
    else $error("Read data changed without a read being taken.");

endmodule

/* File: psos_far_side.sv */
module psos_far_side
(
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [3:0] cfg,
  input  wire logic [1:0] sel,
  output logic            rx_symbol_error,
  output logic      [1:0] phy_addr_strap,
  output logic            wake_enable_strap_pin,
  output logic            rmii_strap_pin,
  output logic      [1:0] mmd_wake_pin_select
);
  timeunit 1ns;
  timeprecision 1ps;

  // Straps are plain levels; they only change while the bench says so.
  assign {wake_enable_strap_pin, rmii_strap_pin, phy_addr_strap} = cfg;
  assign mmd_wake_pin_select = sel;

  // One pulse per errored frame, registered so it never races the bench.
  always @(posedge hclk)
    rx_symbol_error <= go;
endmodule

/* File: psos_pkg.sv */
package psos_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0]  IDX_AFE4     = 6'h13;
  localparam logic [5:0]  IDX_ERRCNT   = 6'h15;
  localparam logic [5:0]  IDX_OVR      = 6'h16;
  localparam logic [5:0]  IDX_STS      = 6'h17;
  localparam logic [5:0]  IDX_INT_STS  = 6'h1E;
  localparam logic [5:0]  IDX_INT_MSK  = 6'h1F;
  localparam logic [5:0]  IDX_NONE     = 6'h00;

  localparam int unsigned AFE4_AMP_BIT = 4;
  localparam logic [15:0] AFE4_RST     = 16'h0000;

  localparam logic [15:0] ERRCNT_RST   = 16'h0000;
  localparam logic [15:0] ERRCNT_MAX   = 16'hFFFF;

  localparam int unsigned OVR_WAKE_BIT = 15;
  localparam int unsigned OVR_RSVD_RO  = 10;
  localparam int unsigned OVR_BCAST    = 9;
  localparam int unsigned OVR_B2B      = 6;
  localparam int unsigned OVR_NAND     = 5;
  localparam int unsigned OVR_RMII     = 1;
  localparam logic [15:0] OVR_RST      = 16'h0002;
  localparam logic [15:0] OVR_WMASK    = 16'hFBFF;

  localparam int unsigned STS_ADDR_LSB = 13;
  localparam int unsigned STS_RMII_BIT = 1;

  localparam int unsigned INT_W        = 2;
  localparam int unsigned INT_ERR      = 0;
  localparam int unsigned INT_OVF      = 1;
  localparam logic [1:0]  INT_RST      = 2'h0;

  localparam logic [1:0]  ADDR_LOW     = 2'h0;
  localparam logic [1:0]  ADDR_HIGH    = 2'h3;
  localparam logic [1:0]  STRAP_SETTLE = 2'h2;
  localparam logic [1:0]  WAKE_PIN_OFF = 2'h0;

endpackage

/* File: psos_strap_if.sv */
interface psos_strap_if;
  logic       captured;
  logic       wake_en;
  logic [1:0] phy_addr;
  logic       rmii;

  modport producer
  (
    output captured,
    output wake_en,
    output phy_addr,
    output rmii
  );

  modport consumer
  (
    input captured,
    input wake_en,
    input phy_addr,
    input rmii
  );
endinterface

/* File: psos_strap_sampler.sv */
module psos_strap_sampler
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        wake_enable_strap_pin,
  input  wire logic [1:0]  phy_addr_strap,
  input  wire logic        rmii_strap_pin,
  psos_strap_if.producer   strap
);

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] cnt;
    logic       done;
    logic       pulse;
    logic [3:0] val;
  } psos_samp_t;

  psos_samp_t q;
  psos_samp_t d;

  always_comb
  begin
    d = q;
    d.sync1 = {rmii_strap_pin, phy_addr_strap, wake_enable_strap_pin};
    d.sync2 = q.sync1;
    d.pulse = 1'b0;
    if (!q.done)
    begin
      // Sampled once, after the synchronisers have filled.
      if (q.cnt == psos_pkg::STRAP_SETTLE)
      begin
        d.done  = 1'b1;
        d.pulse = 1'b1;
        d.val   = q.sync2;
        // Only addresses 0h and 3h exist; a split strap falls back to 0h.
        d.val[2:1] = (q.sync2[2:1] == psos_pkg::ADDR_HIGH)
                     ? psos_pkg::ADDR_HIGH : psos_pkg::ADDR_LOW;
      end
      else
      begin
        d.cnt = q.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign strap.captured = q.pulse;
  assign strap.wake_en  = q.val[0];
  assign strap.phy_addr = q.val[2:1];
  assign strap.rmii     = q.val[3];

  a_strap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    q.done |=> $stable(q.val))
    else $error("Latched strap values changed after capture.");

endmodule

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed
  {
    logic [5:0]  idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } psos_row_t;

  logic        hclk, hresetn, hsel, hwrite, go, hreadyout, hresp, irq;
  logic        rx_symbol_error, wake_enable_strap_pin, rmii_strap_pin;
  logic        reduced_amplitude_ten_meg, power_wake_event_enable;
  logic        broadcast_disable, rmii_back_to_back, nand_tree_mode;
  logic        rmii_mode, mmd_amp;
  wire logic   hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, phy_addr_strap, mmd_wake_pin_select;
  logic [1:0]  wake_pin_function, sel;
  logic [2:0]  hsize;
  logic [3:0]  cfg;
  logic [4:0]  phy_address;
  int          err_count, check_count;

  psos_row_t rows [7] = '{
    '{psos_pkg::IDX_AFE4, 32'hFFFFFFFF, 32'h0000FFFF},
    '{psos_pkg::IDX_OVR, 32'hFFFFFFFF, 32'h0000FBFF},
    '{psos_pkg::IDX_OVR, 32'h00000000, 32'h00000000},
    '{psos_pkg::IDX_ERRCNT, 32'h0000FFFF, 32'h00000000},
    '{psos_pkg::IDX_STS, 32'h00000000, 32'h00006002},
    '{6'h01, 32'hFFFFFFFF, 32'h00000000},
    '{psos_pkg::IDX_INT_MSK, 32'h00000000, 32'h00000000}};

  assign hready = hreadyout;

  phy_strap_override_status_regs u_phy_strap_override_status_regs
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .wake_enable_strap_pin,
    .phy_addr_strap, .rmii_strap_pin, .rx_symbol_error,
    .mmd_wake_pin_select, .reduced_amplitude_ten_meg,
    .power_wake_event_enable, .wake_pin_function, .broadcast_disable,
    .rmii_back_to_back, .nand_tree_mode, .rmii_mode, .phy_address, .irq
  );

  psos_far_side u_psos_far_side
  (
    .hclk, .go, .cfg, .sel, .rx_symbol_error, .phy_addr_strap,
    .wake_enable_strap_pin, .rmii_strap_pin, .mmd_wake_pin_select
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic give_verdict;
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, ex);
    check_count++;
    if (seen !== ex)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, ex, seen);
    end
  endtask

  // One single word transfer; no wait count is assumed, only hready.
  task automatic bus(input logic [5:0] idx, input logic wr,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic reset_with(input logic [3:0] c);
    cfg     <= c;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  initial
  begin
    #100000;
    err_count++;
    give_verdict;
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    hsize = 3'h2;
    go = 1'b0;
    cfg = 4'hF;
    sel = 2'h2;
    mmd_amp = 1'b1;
    @(posedge hclk);
    reset_with(4'hF);
    bus(psos_pkg::IDX_OVR, 1'b0, 32'h0);
    chk("override reset", rd, 32'h00008002);
    bus(psos_pkg::IDX_AFE4, 1'b0, 32'h0);
    chk("afe reset", rd, 32'h00000000);
    chk("phy address", {27'h0, phy_address}, 32'h00000003);
    cfg <= 4'h0;
    repeat (3) @(posedge hclk);
    bus(psos_pkg::IDX_STS, 1'b0, 32'h0);
    chk("status held", rd, 32'h00006002);
    foreach (rows[i])
    begin
      bus(rows[i].idx, 1'b1, rows[i].wd);
      bus(rows[i].idx, 1'b0, 32'h0);
      chk("row readback", rd, rows[i].ex);
    end
    mmd_amp <= 1'b0;
    bus(psos_pkg::IDX_OVR, 1'b1, 32'h00008262);
    bus(psos_pkg::IDX_AFE4, 1'b1, 32'h00000010);
    #1;
    chk("mode outputs", {24'h0, power_wake_event_enable, broadcast_disable,
        rmii_back_to_back, nand_tree_mode, rmii_mode,
        reduced_amplitude_ten_meg, wake_pin_function}, 32'hFE);
    chk("amp", {31'h0, reduced_amplitude_ten_meg}, {31'h0, ~mmd_amp});
    sel <= 2'h1;
    @(posedge hclk);
    chk("pin select", {30'h0, wake_pin_function}, 32'h1);
    mmd_amp <= 1'b1;
    bus(psos_pkg::IDX_OVR, 1'b1, 32'h0);
    bus(psos_pkg::IDX_AFE4, 1'b1, 32'h0);
    #1;
    chk("modes off", {24'h0, power_wake_event_enable, broadcast_disable,
        rmii_back_to_back, nand_tree_mode, rmii_mode,
        reduced_amplitude_ten_meg, wake_pin_function}, 32'h0);
    chk("amp", {31'h0, reduced_amplitude_ten_meg}, {31'h0, ~mmd_amp});
    repeat (3)
    begin
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
    end
    @(posedge hclk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    bus(psos_pkg::IDX_ERRCNT, 1'b0, 32'h0);
    chk("error count", rd, 32'h00000003);
    bus(psos_pkg::IDX_ERRCNT, 1'b0, 32'h0);
    chk("count cleared", rd, 32'h00000000);
    bus(psos_pkg::IDX_INT_STS, 1'b0, 32'h0);
    chk("event status", rd, 32'h00000001);
    bus(psos_pkg::IDX_INT_MSK, 1'b1, 32'h1);
    #1;
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(psos_pkg::IDX_INT_STS, 1'b1, 32'h1);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // An event in the data phase of the clearing write must survive it.
    go <= 1'b1;
    fork
      bus(psos_pkg::IDX_INT_STS, 1'b1, 32'h1);
      begin
        @(posedge hclk);
        go <= 1'b0;
      end
    join
    #1;
    chk("set wins", {31'h0, irq}, 32'h1);
    bus(psos_pkg::IDX_INT_STS, 1'b1, 32'h1);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // A split address strap must fall back to address zero.
    reset_with(4'h1);
    bus(psos_pkg::IDX_OVR, 1'b0, 32'h0);
    chk("override rerst", rd, 32'h00000002);
    bus(psos_pkg::IDX_STS, 1'b0, 32'h0);
    chk("status rerst", rd, 32'h00000000);
    chk("phy addr zero", {27'h0, phy_address}, 32'h0);
    give_verdict;
  end
endmodule
